//--- common/swk_mode_pkg.sv
`default_nettype none
package swk_mode_pkg;

    // ------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_OFF = 3'h0;
    localparam logic [2:0] SEL_WAKE = 3'h1;
    localparam logic [2:0] SEL_RX = 3'h2;
    localparam logic [2:0] SEL_NORMAL = 3'h3;
    localparam logic [2:0] SEL_OFF_HI = 3'h4;
    localparam logic [2:0] SEL_SWK = 3'h5;
    localparam logic [2:0] SEL_RX_SWK = 3'h6;
    localparam logic [2:0] SEL_NORMAL_SWK = 3'h7;
    localparam int SEL_TOP_BIT = 2;

    // ------------------------------------------------------------
    // Counter and reset values
    // ------------------------------------------------------------
    localparam int ERR_CNT_W = 6;
    localparam logic [5:0] ERR_CNT_OVERFLOW = 6'h20;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [5:0] BIT_QUANTA_RESET = 6'h00;
    localparam logic [5:0] SAMPLE_POINT_RESET = 6'h33;

    // Power modes of the chip
    typedef enum logic [2:0] {
        PWR_NORMAL = 3'b000,
        PWR_STOP = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_RESTART = 3'b011,
        PWR_FAILSAFE = 3'b100
    } power_mode_t;

    // Effective transceiver operation
    typedef enum logic [2:0] {
        XCVR_OFF = 3'b000,
        XCVR_WAKE = 3'b001,
        XCVR_RX = 3'b010,
        XCVR_NORMAL = 3'b011,
        XCVR_SWK = 3'b100,
        XCVR_RX_SWK = 3'b101,
        XCVR_NORMAL_SWK = 3'b110
    } xcvr_mode_t;

    // Selector asks for selective wake
    function automatic logic sel_is_swk(input logic [2:0] sel);
        return sel[SEL_TOP_BIT] && (sel != SEL_OFF_HI);
    endfunction

    // Selector is an off code
    function automatic logic sel_is_off(input logic [2:0] sel);
        return sel[1:0] == 2'h0;
    endfunction

endpackage
`default_nettype wire

//--- common/swk_wake_if.sv
`timescale 1ns/1ps
`default_nettype none
// Wake events from the frame monitor to the mode controller
interface swk_wake_if;
    logic frame_wake;
    logic pattern_wake;
    logic overflow_wake;
    logic frame_in_silence;
    logic [5:0] err_count;
    logic detect_enable;
    logic clear_count;
    modport monitor (output frame_wake, output pattern_wake, output overflow_wake,
        output frame_in_silence, output err_count, input detect_enable, input clear_count);
    modport ctrl (input frame_wake, input pattern_wake, input overflow_wake,
        input frame_in_silence, input err_count, output detect_enable, output clear_count);
endinterface
`default_nettype wire

//--- hw/swk_frame_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Qualifies bus events and keeps the frame error counter
module swk_frame_monitor
    import swk_mode_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Bus events
    input wire logic wake_frame_seen_in,
    input wire logic wake_pattern_seen_in,
    input wire logic frame_error_in,
    input wire logic frame_good_in,
    input wire logic silence_timer_running_in,
    // Controller side
    swk_wake_if.monitor wk
);
    logic [5:0] count_reg, count_next;

    // ------------------------------------------------------------
    // Error counter
    // ------------------------------------------------------------
    // Counter saturates at overflow so the reported value stays put
    always_comb begin
        count_next = count_reg;
        if (wk.clear_count) begin
            count_next = 6'h00;
        end else if (frame_error_in && count_reg != ERR_CNT_OVERFLOW) begin
            count_next = count_reg + 6'h01;
        end else if (frame_good_in && count_reg != 6'h00 && count_reg != ERR_CNT_OVERFLOW) begin
            count_next = count_reg - 6'h01;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_reg <= 6'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    // Frames only count while detection is armed without error
    assign wk.frame_wake = wake_frame_seen_in && wk.detect_enable;
    assign wk.pattern_wake = wake_pattern_seen_in;
    assign wk.overflow_wake = wk.detect_enable && frame_error_in
        && count_reg == ERR_CNT_OVERFLOW - 6'h01;
    assign wk.frame_in_silence = silence_timer_running_in;
    assign wk.err_count = count_reg;

    // Reported overflow must stand until the selector leaves selective wake
    count_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        count_reg == ERR_CNT_OVERFLOW && !wk.clear_count |=> wk.err_count == ERR_CNT_OVERFLOW)
        else $error("overflow count not held");
endmodule
`default_nettype wire

//--- hw/swk_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Selective-wake mode controller of the CAN transceiver
module swk_mode_ctrl
    import swk_mode_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Power mode of the chip
    input wire logic [2:0] power_mode_in,
    // Controller writes
    input wire logic sel_write_in,
    input wire logic [2:0] sel_wdata_in,
    input wire logic cfg_valid_set_in,
    input wire logic cfg_changed_in,
    input wire logic error_clear_in,
    input wire logic wake_flags_clear_in,
    input wire logic [5:0] bit_time_quanta_in,
    input wire logic [5:0] sample_point_in,
    input wire logic wake_receiver_select_in,
    // Bus events
    input wire logic wake_frame_seen_in,
    input wire logic wake_pattern_seen_in,
    input wire logic frame_error_in,
    input wire logic frame_good_in,
    input wire logic silence_timer_running_in,
    // Status
    output logic [2:0] can_mode_sel_out,
    output logic [2:0] xcvr_mode_out,
    output logic selwake_error_flag_out,
    output logic filter_config_valid_out,
    output logic can_wake_flag_out,
    output logic wake_pattern_flag_out,
    output logic wake_frame_flag_out,
    output logic [5:0] frame_error_count_out,
    output logic wake_interrupt_out,
    output logic restart_request_out,
    // Protocol handler settings
    output logic [5:0] bit_time_quanta_out,
    output logic [5:0] sample_point_out,
    output logic wake_receiver_select_out
);
    swk_wake_if wk ();

    power_mode_t pwr;
    power_mode_t pwr_prev_reg, pwr_prev_next;
    logic [2:0] sel_reg, sel_next;
    logic err_reg, err_next;
    logic cfg_reg, cfg_next;
    logic canwu_reg, canwu_next;
    logic wup_reg, wup_next;
    logic wuf_reg, wuf_next;
    logic armed_reg, armed_next;
    logic failsafe_reg, failsafe_next;
    logic [5:0] btq_reg, btq_next;
    logic [5:0] spt_reg, spt_next;
    logic rxsel_reg, rxsel_next;
    logic irq_reg, irq_next;
    logic rst_reg, rst_next;
    logic entering_stop, entering_sleep, entering_restart, entering_fs, from_sleep;
    logic can_wake, swk_active;
    xcvr_mode_t xm;

    assign pwr = power_mode_t'(power_mode_in);
    assign entering_stop = pwr == PWR_STOP && pwr_prev_reg != PWR_STOP;
    assign entering_sleep = pwr == PWR_SLEEP && pwr_prev_reg != PWR_SLEEP;
    assign entering_restart = pwr == PWR_RESTART && pwr_prev_reg != PWR_RESTART;
    assign entering_fs = pwr == PWR_FAILSAFE && pwr_prev_reg != PWR_FAILSAFE;
    assign from_sleep = pwr_prev_reg == PWR_SLEEP;

    // Selective wake live only with clear error flag and selector asking for it
    assign swk_active = sel_is_swk(sel_reg) && !err_reg && !failsafe_reg;
    assign wk.detect_enable = swk_active && armed_reg;
    assign wk.clear_count = !sel_is_swk(sel_reg);

    // ------------------------------------------------------------
    // Frame monitor
    // ------------------------------------------------------------
    swk_frame_monitor u_mon (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .wake_frame_seen_in(wake_frame_seen_in),
        .wake_pattern_seen_in(wake_pattern_seen_in),
        .frame_error_in(frame_error_in),
        .frame_good_in(frame_good_in),
        .silence_timer_running_in(silence_timer_running_in),
        .wk(wk.monitor)
    );

    // A pattern wakes only a wake-capable transceiver without live selective wake
    assign can_wake = armed_reg && !sel_is_off(sel_reg)
        && (wk.frame_wake || wk.overflow_wake || (wk.pattern_wake && !swk_active));

    // ------------------------------------------------------------
    // Selector, flags and arming
    // ------------------------------------------------------------
    // Hardware sets win over software clears on the same edge
    always_comb begin
        pwr_prev_next = pwr;
        sel_next = sel_reg;
        err_next = err_reg;
        cfg_next = cfg_reg;
        canwu_next = canwu_reg;
        wup_next = wup_reg;
        wuf_next = wuf_reg;
        armed_next = armed_reg;
        failsafe_next = failsafe_reg;
        irq_next = 1'b0;
        rst_next = 1'b0;
        // Selector writes land only in normal power mode
        if (pwr == PWR_NORMAL && sel_write_in) begin
            if (sel_wdata_in != sel_reg) begin
                armed_next = 1'b1;
                if (sel_is_swk(sel_wdata_in)) begin
                    wuf_next = 1'b0;
                    wup_next = 1'b0;
                    // Config check on enabling selective wake
                    err_next = !cfg_reg;
                end
            end
            sel_next = sel_wdata_in;
            failsafe_next = 1'b0;
        end
        if (cfg_valid_set_in && pwr == PWR_NORMAL) begin
            cfg_next = 1'b1;
        end
        if (cfg_changed_in && pwr == PWR_NORMAL) begin
            cfg_next = 1'b0;
            if (sel_is_swk(sel_reg)) begin
                err_next = 1'b1;
            end
        end
        // Error cannot clear while selective wake lacks valid config
        if (error_clear_in && !(sel_reg[SEL_TOP_BIT] && !cfg_next)) begin
            err_next = 1'b0;
        end
        if (wake_flags_clear_in) begin
            canwu_next = 1'b0;
        end
        if (entering_stop) begin
            // Selector untouched; effective mode derives from it
            sel_next = sel_reg;
        end
        if (entering_sleep) begin
            armed_next = 1'b1;
            if (sel_is_swk(sel_reg)) begin
                wuf_next = 1'b0;
                sel_next = SEL_SWK;
            end else if (sel_reg == SEL_RX || sel_reg == SEL_NORMAL) begin
                sel_next = SEL_WAKE;
            end
        end
        if (entering_restart && !from_sleep) begin
            cfg_next = 1'b0;
            if (sel_is_swk(sel_reg)) begin
                sel_next = SEL_SWK;
                err_next = 1'b1;
            end else if (sel_reg == SEL_RX || sel_reg == SEL_NORMAL) begin
                sel_next = SEL_WAKE;
            end
        end
        if (entering_restart && from_sleep) begin
            cfg_next = 1'b0;
        end
        if (entering_fs) begin
            failsafe_next = 1'b1;
        end
        if (can_wake) begin
            canwu_next = 1'b1;
            armed_next = 1'b0;
            if (wk.frame_wake) begin
                wuf_next = 1'b1;
                wup_next = wup_reg || !wk.frame_in_silence;
            end else if (wk.overflow_wake) begin
                err_next = 1'b1;
            end else begin
                wup_next = 1'b1;
            end
            if (pwr == PWR_SLEEP) begin
                rst_next = 1'b1;
            end else begin
                irq_next = 1'b1;
            end
        end
    end

    // Protocol handler settings are taken only in normal mode
    always_comb begin
        btq_next = btq_reg;
        spt_next = spt_reg;
        rxsel_next = rxsel_reg;
        if (pwr == PWR_NORMAL) begin
            btq_next = bit_time_quanta_in;
            spt_next = sample_point_in;
            rxsel_next = wake_receiver_select_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_prev_reg <= PWR_NORMAL;
            sel_reg <= SEL_RESET;
            err_reg <= 1'b0;
            cfg_reg <= 1'b0;
            canwu_reg <= 1'b0;
            wup_reg <= 1'b0;
            wuf_reg <= 1'b0;
            armed_reg <= 1'b1;
            failsafe_reg <= 1'b0;
            btq_reg <= BIT_QUANTA_RESET;
            spt_reg <= SAMPLE_POINT_RESET;
            rxsel_reg <= 1'b0;
            irq_reg <= 1'b0;
            rst_reg <= 1'b0;
        end else begin
            pwr_prev_reg <= pwr_prev_next;
            sel_reg <= sel_next;
            err_reg <= err_next;
            cfg_reg <= cfg_next;
            canwu_reg <= canwu_next;
            wup_reg <= wup_next;
            wuf_reg <= wuf_next;
            armed_reg <= armed_next;
            failsafe_reg <= failsafe_next;
            btq_reg <= btq_next;
            spt_reg <= spt_next;
            rxsel_reg <= rxsel_next;
            irq_reg <= irq_next;
            rst_reg <= rst_next;
        end
    end

    // ------------------------------------------------------------
    // Effective transceiver mode
    // ------------------------------------------------------------
    // Derived from the selector each cycle so readback never lies
    always_comb begin
        xm = XCVR_OFF;
        if (failsafe_reg) begin
            xm = XCVR_WAKE;
        end else if (sel_is_off(sel_reg)) begin
            xm = XCVR_OFF;
        end else if (pwr == PWR_SLEEP || pwr == PWR_RESTART) begin
            xm = swk_active ? XCVR_SWK : XCVR_WAKE;
        end else begin
            unique case (sel_reg[1:0])
                2'h1: xm = swk_active ? XCVR_SWK : XCVR_WAKE;
                2'h2: xm = swk_active ? XCVR_RX_SWK : XCVR_RX;
                default: begin
                    if (pwr == PWR_STOP && !sel_reg[SEL_TOP_BIT]) begin
                        xm = XCVR_WAKE;
                    end else begin
                        xm = swk_active ? XCVR_NORMAL_SWK : XCVR_NORMAL;
                    end
                end
            endcase
        end
    end

    assign can_mode_sel_out = sel_reg;
    assign xcvr_mode_out = xm;
    assign selwake_error_flag_out = err_reg;
    assign filter_config_valid_out = cfg_reg;
    assign can_wake_flag_out = canwu_reg;
    assign wake_pattern_flag_out = wup_reg;
    assign wake_frame_flag_out = wuf_reg;
    assign frame_error_count_out = wk.err_count;
    assign wake_interrupt_out = irq_reg;
    assign restart_request_out = rst_reg;
    assign bit_time_quanta_out = btq_reg;
    assign sample_point_out = spt_reg;
    assign wake_receiver_select_out = rxsel_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sleep_fold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        entering_sleep && sel_is_swk(sel_reg) && pwr == PWR_SLEEP |=> sel_reg == SEL_SWK)
        else $error("sleep entry did not fold to 101");
    sleep_modes_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        pwr == PWR_SLEEP |-> xm inside {XCVR_OFF, XCVR_WAKE, XCVR_SWK})
        else $error("illegal mode in sleep");
    stop_normal_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        pwr == PWR_STOP && sel_reg == SEL_NORMAL && !failsafe_reg |-> xm == XCVR_WAKE)
        else $error("stop normal not wake capable");
    stop_error_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        pwr == PWR_STOP && err_reg && sel_reg == SEL_RX_SWK && !failsafe_reg |-> xm == XCVR_RX)
        else $error("stop error mode wrong");
    restart_err_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        entering_restart && !from_sleep && sel_is_swk(sel_reg) |=> err_reg && sel_reg == SEL_SWK)
        else $error("restart from normal wrong");
    failsafe_wake_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        entering_fs |=> xm == XCVR_WAKE)
        else $error("fail-safe not wake capable");
    frame_flags_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        can_wake && wk.frame_wake |=> canwu_reg && wuf_reg)
        else $error("frame wake flags missing");
    wake_route_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        can_wake && pwr == PWR_SLEEP |=> rst_reg && !irq_reg)
        else $error("sleep wake did not restart");
    sleep_rearm_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        entering_sleep && !can_wake |=> armed_reg)
        else $error("sleep entry did not rearm");
endmodule
`default_nettype wire

//--- bench/swk_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus decoder stand-in: one-cycle event pulses and the silence level
module swk_bus_model (
    // Clock
    input wire logic core_clk_in,
    // Decoder events
    output logic frame_out,
    output logic pattern_out,
    output logic error_out,
    output logic good_out,
    output logic silence_out
);
    // Quiet bus until told otherwise
    initial begin
        {good_out, error_out, pattern_out, frame_out} = 4'h0;
        silence_out = 1'b0;
    end

    // Kind 0 frame, 1 pattern, 2 error, 3 good; high across exactly one edge
    task automatic pulse(input int kind);
        @(posedge core_clk_in);
        #1;
        {good_out, error_out, pattern_out, frame_out} = 4'h1 << kind;
        @(posedge core_clk_in);
        #1;
        {good_out, error_out, pattern_out, frame_out} = 4'h0;
    endtask

    // Level stays until the next call, as a silence timer would
    task automatic silence(input logic v);
        silence_out = v;
    endtask
endmodule
`default_nettype wire

//--- bench/can_selective_wake_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_selective_wake_mode_control_tb;
    import swk_mode_pkg::*;
    localparam logic [4:0] W = 5'h01, V = 5'h02, C = 5'h04, E = 5'h08, F = 5'h10;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] pmode = PWR_NORMAL;
    logic [4:0] stb = 5'h00;
    logic [2:0] wdata = 3'h0;
    logic [5:0] quanta = 6'h00;
    logic [5:0] spt = 6'h00;
    logic rxsel = 1'b0;
    logic [2:0] sel, xcvr;
    logic err, cfgv, cw, wake_pattern_flag, wake_frame_flag, irq, rreq, rxsel_q;
    logic [5:0] cnt, quanta_q, spt_q;
    wire logic wfs, wps, fe, fg, sil;
    int n_fail = 0;
    int total_checks = 0;
    power_mode_t modes[3] = '{PWR_STOP, PWR_SLEEP, PWR_RESTART};

    // 125 MHz core clock
    always #4 core_clk_in = ~core_clk_in;

    swk_bus_model bus (.core_clk_in(core_clk_in), .frame_out(wfs), .pattern_out(wps),
        .error_out(fe), .good_out(fg), .silence_out(sil));

    swk_mode_ctrl DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .power_mode_in(pmode), .sel_write_in(stb[0]), .sel_wdata_in(wdata),
        .cfg_valid_set_in(stb[1]), .cfg_changed_in(stb[2]), .error_clear_in(stb[3]),
        .wake_flags_clear_in(stb[4]), .bit_time_quanta_in(quanta), .sample_point_in(spt),
        .wake_receiver_select_in(rxsel), .wake_frame_seen_in(wfs),
        .wake_pattern_seen_in(wps), .frame_error_in(fe), .frame_good_in(fg),
        .silence_timer_running_in(sil), .can_mode_sel_out(sel), .xcvr_mode_out(xcvr),
        .selwake_error_flag_out(err), .filter_config_valid_out(cfgv),
        .can_wake_flag_out(cw), .wake_pattern_flag_out(wake_pattern_flag), .wake_frame_flag_out(wake_frame_flag),
        .frame_error_count_out(cnt), .wake_interrupt_out(irq), .restart_request_out(rreq),
        .bit_time_quanta_out(quanta_q), .sample_point_out(spt_q),
        .wake_receiver_select_out(rxsel_q));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Controller write strobes, one cycle wide, idle cycle between calls
    task automatic hit(input logic [4:0] s, input logic [2:0] d);
        @(posedge core_clk_in);
        #1;
        stb = s;
        wdata = d;
        @(posedge core_clk_in);
        #1;
        stb = 5'h00;
    endtask

    // Three edges let the transition detector and the registers settle
    task automatic go(input power_mode_t m);
        @(posedge core_clk_in);
        #1;
        pmode = m;
        repeat (3) @(posedge core_clk_in);
        #1;
    endtask

    // Sleep is only left through restart, as the chip does
    task automatic leave(input power_mode_t m);
        if (m == PWR_SLEEP) go(PWR_RESTART);
        go(PWR_NORMAL);
    endtask

    // Rearm, validate, clear error, then program the wanted selector
    task automatic prep(input logic [2:0] s, input logic e);
        // Rearming selective wake first drops frame and pattern flags of earlier tests
        hit(W, SEL_OFF);
        hit(W, SEL_SWK);
        hit(W, SEL_OFF);
        hit(V, SEL_OFF);
        hit(E, SEL_OFF);
        hit(W, s);
        if (e) hit(C, s);
        if (s[2] && s[1:0] != 2'h0 && !e) begin
            chk(err, 1'b0);
            chk(wake_frame_flag, 1'b0);
        end
    endtask

    // Four samples cover the one-edge answer with margin
    task automatic catch_pulse(input logic want_irq, output logic seen);
        seen = 1'b0;
        repeat (4) begin
            if ((want_irq ? irq : rreq) === 1'b1) seen = 1'b1;
            @(posedge core_clk_in);
            #1;
        end
    endtask

    // Returns {error, selector, effective mode} after entering power mode m
    function automatic logic [6:0] expect_mode(input power_mode_t m, input logic [2:0] s,
        input logic e);
        logic off;
        logic sw;
        logic [2:0] x;
        logic [2:0] so;
        off = (s[1:0] == 2'h0);
        sw = s[2] && !off;
        so = off ? s : (sw ? SEL_SWK : SEL_WAKE);
        x = (sw && !e) ? XCVR_SWK : XCVR_WAKE;
        if (m == PWR_STOP) begin
            so = s;
            x = (s == SEL_NORMAL) ? XCVR_WAKE : {1'b0, s[1:0]} + ((sw && !e) ? 3'h3 : 3'h0);
        end else if (m == PWR_RESTART) x = XCVR_WAKE;
        if (off) x = XCVR_OFF;
        return {(m == PWR_RESTART) ? sw : e, so, x};
    endfunction

    // Sleep, one wake cause, then the flags f under mask m: {wake, pattern, frame, error}
    task automatic sleep_wake(input logic [2:0] s, input logic e, input int kind,
        input logic quiet, input logic [3:0] f, input logic [3:0] m);
        logic seen;
        prep(s, e);
        bus.silence(quiet);
        go(PWR_SLEEP);
        if (kind == 2) repeat (32) bus.pulse(2);
        else bus.pulse(kind);
        catch_pulse(1'b0, seen);
        chk(seen, 1'b1);
        chk({cw, wake_pattern_flag, wake_frame_flag, err} & m, f & m);
        if (kind == 2) chk(cnt, ERR_CNT_OVERFLOW);
        go(PWR_RESTART);
        chk(cfgv, 1'b0);
        chk(sel, s[2] ? SEL_SWK : s);
        hit(F, SEL_OFF);
        go(PWR_NORMAL);
        $display("test sleep wake kind %0d done", kind);
    endtask

    // Generous bound, close to fifty times the expected run
    initial begin
        #400000;
        n_fail++;
        test_done();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [6:0] exp;
        logic seen;
        repeat (2) @(posedge core_clk_in);
        #1;
        resetn_in = 1'b1;
        chk(sel, SEL_RESET);
        chk({err, cfgv, cw, wake_pattern_flag, wake_frame_flag}, 5'h00);
        chk(cnt, 6'h00);
        chk(spt_q, SAMPLE_POINT_RESET);
        chk(quanta_q, BIT_QUANTA_RESET);
        for (int s = 0; s < 8; s++)
            for (int e = 0; e < 2; e++)
                if (e == 0 || (s[2] && s[1:0] != 2'h0))
                    foreach (modes[i]) begin
                        prep(s[2:0], e[0]);
                        go(modes[i]);
                        exp = expect_mode(modes[i], s[2:0], e[0]);
                        chk(sel, exp[5:3]);
                        chk(xcvr, exp[2:0]);
                        chk(err, exp[6]);
                        leave(modes[i]);
                    end
        $display("test mode tables done");
        sleep_wake(SEL_SWK, 1'b0, 0, 1'b1, 4'ha, 4'hf);
        sleep_wake(SEL_SWK, 1'b0, 0, 1'b0, 4'he, 4'hf);
        sleep_wake(SEL_WAKE, 1'b0, 1, 1'b0, 4'hc, 4'hf);
        sleep_wake(SEL_SWK, 1'b0, 2, 1'b1, 4'h9, 4'hb);
        sleep_wake(SEL_SWK, 1'b1, 1, 1'b0, 4'hd, 4'hf);
        prep(SEL_NORMAL_SWK, 1'b0);
        bus.silence(1'b1);
        bus.pulse(0);
        catch_pulse(1'b1, seen);
        chk(seen, 1'b1);
        chk({cw, wake_frame_flag}, 2'h3);
        hit(F, SEL_OFF);
        go(PWR_SLEEP);
        chk(xcvr, XCVR_SWK);
        bus.pulse(0);
        catch_pulse(1'b0, seen);
        chk(seen, 1'b1);
        leave(PWR_SLEEP);
        $display("test normal wake and rearm done");
        prep(SEL_SWK, 1'b1);
        bus.pulse(0);
        catch_pulse(1'b1, seen);
        chk(seen, 1'b0);
        chk(wake_frame_flag, 1'b0);
        prep(SEL_NORMAL_SWK, 1'b0);
        go(PWR_FAILSAFE);
        chk(xcvr, XCVR_WAKE);
        go(PWR_NORMAL);
        prep(SEL_SWK, 1'b0);
        go(PWR_STOP);
        hit(W, SEL_RX);
        chk(sel, SEL_SWK);
        go(PWR_NORMAL);
        $display("test error, fail-safe, refused write done");
        quanta = 6'h15;
        spt = 6'h2a;
        rxsel = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1;
        chk(rxsel_q, 1'b1);
        chk(quanta_q, 6'h15);
        chk(spt_q, 6'h2a);
        $display("test protocol settings done");
        test_done();
    end
endmodule
`default_nettype wire
